// >>> hdl/rcms_consts.svh
// Purpose: Constants for the reset clock mode selector.
// Assumes: One 50 MHz clock, AXI4-Lite register access.
// Notes: Factors are held in half units (value times two).
`ifndef RCMS_CONSTS_SVH
`define RCMS_CONSTS_SVH

// ============================================================
// Register map (byte addresses)
`define RCMS_ADDR_STATUS 4'h0
`define RCMS_ADDR_FACTORS 4'h4
`define RCMS_ADDR_CODE 4'h8
`define RCMS_ADDR_SCRATCH 4'hC
`define RCMS_RESP_OKAY 2'h0
`define RCMS_RESP_DECERR 2'h3

// ============================================================
// Configuration word and code layout
`define RCMS_HCW_HIGH_LSB 28
`define RCMS_DEFAULT_HIGH 4'h0

// ============================================================
// Default-mode factors, half units
`define RCMS_DEF_CPM 8'h06
`define RCMS_DEF_CPU 8'h08
`define RCMS_DEF_DIV 8'h00

`endif

// >>> hdl/rcms_pkg.sv
// Purpose: Types for the reset clock mode selector.
// Assumes: Included constants header.
// Notes: Factors are in half units.
package rcms_pkg;
	typedef enum logic [1:0] {
		RCMS_LOCAL_BUS,
		RCMS_PCI_HOST,
		RCMS_PCI_AGENT
	} rcms_mode_t;

	typedef struct packed {
		logic [7:0] cpm_x2;
		logic [7:0] cpu_x2;
		logic [7:0] div_x2;
		logic reserved;
	} rcms_factors_t;

	typedef struct packed {
		logic pci_disable_strap;
		logic host_agent_strap;
		logic [2:0] clock_mode_pins;
		logic [31:0] config_word;
		logic [5:0] local_general_lines;
	} rcms_straps_t;
endpackage

// >>> hdl/rcms_selector.sv
// Purpose: Latch clock mode at power-on reset, pick PLL factors, make ticks.
// Assumes: Straps stable while power_on_reset_in is high.
// Notes: Only a sample of the factor table is held; other codes report
// reserved and keep the default-mode factors.
`timescale 1ns/1ns
`default_nettype none
`include "rcms_consts.svh"

module rcms_selector
	import rcms_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic power_on_reset_in,
	input wire rcms_straps_t straps,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output rcms_mode_t mode_reg,
	output logic pci_low_range_reg,
	output logic [6:0] config_code_reg,
	output rcms_factors_t factors_reg,
	output logic [3:0] tick_reg
);

	// ============================================================
	// Mode and code formation
	rcms_mode_t mode_next;
	logic range_next;
	logic [3:0] clock_mode_high_bits;
	logic [6:0] code_next;
	rcms_factors_t factors_next;
	logic [7:0] scratch_reg;
	logic [1:0] phase_reg;
	logic tick_spread_reg;

	always_comb begin
		if (straps.pci_disable_strap) begin
			mode_next = RCMS_LOCAL_BUS;
		end else if (straps.host_agent_strap) begin
			mode_next = RCMS_PCI_AGENT;
		end else begin
			mode_next = RCMS_PCI_HOST;
		end
	end

	always_comb begin
		if (straps.pci_disable_strap) begin
			range_next = 1'b0;
			clock_mode_high_bits =
				straps.config_word[`RCMS_HCW_HIGH_LSB +: 4];
		end else begin
			range_next = straps.local_general_lines[5];
			clock_mode_high_bits = {straps.local_general_lines[0],
				straps.local_general_lines[1],
				straps.local_general_lines[2],
				straps.local_general_lines[3]};
		end
		code_next = {clock_mode_high_bits, straps.clock_mode_pins};
	end

	// ============================================================
	// Factor table, half units; reserved codes flagged
	always_comb begin
		factors_next = '{cpm_x2: `RCMS_DEF_CPM, cpu_x2: `RCMS_DEF_CPU,
			div_x2: `RCMS_DEF_DIV, reserved: 1'b0};
		unique case (mode_next)
			RCMS_LOCAL_BUS: begin
				unique case (code_next)
					7'h00: factors_next = '{8'h06, 8'h08, 8'h00, 1'b0};
					7'h01: factors_next = '{8'h06, 8'h0A, 8'h00, 1'b0};
					7'h02: factors_next = '{8'h08, 8'h08, 8'h00, 1'b0};
					7'h03: factors_next = '{8'h08, 8'h0A, 8'h00, 1'b0};
					7'h04: factors_next = '{8'h04, 8'h05, 8'h00, 1'b0};
					7'h05: factors_next = '{8'h04, 8'h06, 8'h00, 1'b0};
					7'h06: factors_next = '{8'h05, 8'h05, 8'h00, 1'b0};
					7'h07: factors_next = '{8'h05, 8'h06, 8'h00, 1'b0};
					7'h08: factors_next = '{8'h04, 8'h08, 8'h00, 1'b0};
					default: factors_next.reserved = 1'b1;
				endcase
			end
			RCMS_PCI_HOST: begin
				unique case (code_next)
					7'h09: factors_next = '{8'h06, 8'h0C, 8'h06, 1'b0};
					7'h0A: factors_next = '{8'h06, 8'h0E, 8'h06, 1'b0};
					7'h0B: factors_next = '{8'h06, 8'h10, 8'h06, 1'b0};
					7'h10: factors_next = '{8'h08, 8'h0A, 8'h08, 1'b0};
					7'h11: factors_next = '{8'h08, 8'h0C, 8'h08, 1'b0};
					7'h18: factors_next = '{8'h0A, 8'h0A, 8'h0A, 1'b0};
					7'h21: factors_next = '{8'h0C, 8'h0C, 8'h0C, 1'b0};
					7'h29: factors_next = '{8'h04, 8'h06, 8'h04, 1'b0};
					default: factors_next.reserved = 1'b1;
				endcase
			end
			RCMS_PCI_AGENT: begin
				unique case (code_next)
					7'h00: factors_next = '{8'h04, 8'h05, 8'h04, 1'b0};
					7'h01: factors_next = '{8'h04, 8'h06, 8'h04, 1'b0};
					7'h02: factors_next = '{8'h06, 8'h06, 8'h06, 1'b0};
					7'h03: factors_next = '{8'h06, 8'h08, 8'h06, 1'b0};
					7'h04: factors_next = '{8'h06, 8'h06, 8'h05, 1'b0};
					7'h09: factors_next = '{8'h04, 8'h0A, 8'h08, 1'b0};
					7'h11: factors_next = '{8'h06, 8'h06, 8'h05, 1'b0};
					default: factors_next.reserved = 1'b1;
				endcase
			end
			default: factors_next.reserved = 1'b1;
		endcase
	end

	// ============================================================
	// Capture only under power-on reset; running clocks stay put after
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_reg <= RCMS_LOCAL_BUS;
			pci_low_range_reg <= 1'b0;
			config_code_reg <= 7'h00;
			factors_reg <= '{`RCMS_DEF_CPM, `RCMS_DEF_CPU, `RCMS_DEF_DIV, 1'b0};
		end else if (power_on_reset_in) begin
			mode_reg <= mode_next;
			pci_low_range_reg <= range_next;
			config_code_reg <= code_next;
			factors_reg <= factors_next;
		end
	end

	// ============================================================
	// Tick generator: aclk models four internal phases per input cycle.
	// Phase 0 is the input rise, phase 2 the fall; phases 1 and 3 are
	// spaced by the ratio (odd half-unit CPU factor shifts them).
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			phase_reg <= 2'h0;
			tick_spread_reg <= 1'b0;
		end else begin
			phase_reg <= phase_reg + 2'h1;
			tick_spread_reg <= factors_reg.cpu_x2[0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tick_reg <= 4'h0;
		end else begin
			tick_reg[0] <= (phase_reg == 2'h0);
			tick_reg[2] <= (phase_reg == 2'h2);
			tick_reg[1] <= tick_spread_reg ? (phase_reg == 2'h0)
				: (phase_reg == 2'h1);
			tick_reg[3] <= tick_spread_reg ? (phase_reg == 2'h2)
				: (phase_reg == 2'h3);
		end
	end

	// ============================================================
	// AXI4-Lite slave; valid, data and response outputs registered on the rising edge, readies decoded from state
	logic aw_held, w_held;
	logic [3:0] aw_addr_reg;
	logic aw_far_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;

	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr_reg <= 4'h0;
			aw_far_reg <= 1'b0;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
		end else if (aw_held && w_held) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr_reg <= s_axi_awaddr[3:0];
				aw_far_reg <= |s_axi_awaddr[31:4];
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RCMS_RESP_OKAY;
			scratch_reg <= 8'h00;
		end else if (aw_held && w_held) begin
			s_axi_bvalid <= 1'b1;
			if (aw_far_reg) begin
				s_axi_bresp <= `RCMS_RESP_DECERR;
			end else if (aw_addr_reg == `RCMS_ADDR_SCRATCH) begin
				s_axi_bresp <= `RCMS_RESP_OKAY;
				if (w_strb_reg[0]) begin
					scratch_reg <= w_data_reg[7:0];
				end
			end else if (aw_addr_reg[1:0] == 2'h0 &&
				aw_addr_reg != `RCMS_ADDR_SCRATCH) begin
				s_axi_bresp <= `RCMS_RESP_OKAY;
			end else begin
				s_axi_bresp <= `RCMS_RESP_DECERR;
			end
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `RCMS_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready &&
			s_axi_araddr[31:4] != 28'h0) begin
			// Upper bits set: outside the map, so no aliasing onto it
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `RCMS_RESP_DECERR;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `RCMS_RESP_OKAY;
			unique case (s_axi_araddr[3:0])
				`RCMS_ADDR_STATUS: s_axi_rdata <= {27'h0, factors_reg.reserved,
					pci_low_range_reg, 1'b0, mode_reg};
				`RCMS_ADDR_FACTORS: s_axi_rdata <= {8'h00,
					factors_reg.cpm_x2, factors_reg.cpu_x2,
					factors_reg.div_x2};
				`RCMS_ADDR_CODE: s_axi_rdata <= {25'h0, config_code_reg};
				`RCMS_ADDR_SCRATCH: s_axi_rdata <= {24'h0, scratch_reg};
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= `RCMS_RESP_DECERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ============================================================
	// Checks
	a_local_mode_pick: assert property (@(posedge aclk)
		disable iff (!aresetn)
		power_on_reset_in && straps.pci_disable_strap |=>
		mode_reg == RCMS_LOCAL_BUS) else $error("local mode not chosen");
	a_agent_mode_pick: assert property (@(posedge aclk)
		disable iff (!aresetn)
		power_on_reset_in && !straps.pci_disable_strap &&
		straps.host_agent_strap |=> mode_reg == RCMS_PCI_AGENT)
		else $error("agent mode not chosen");
	a_range_from_line: assert property (@(posedge aclk)
		disable iff (!aresetn)
		power_on_reset_in && !straps.pci_disable_strap |=>
		pci_low_range_reg == $past(straps.local_general_lines[5]))
		else $error("range select wrong");
	a_code_low_pins: assert property (@(posedge aclk)
		disable iff (!aresetn)
		power_on_reset_in |=>
		config_code_reg[2:0] == $past(straps.clock_mode_pins))
		else $error("mode pins not in code");
	a_code_high_lines: assert property (@(posedge aclk)
		disable iff (!aresetn)
		power_on_reset_in && !straps.pci_disable_strap |=>
		config_code_reg[6] == $past(straps.local_general_lines[0]))
		else $error("line zero not code msb");
	a_hold_after_por: assert property (@(posedge aclk)
		disable iff (!aresetn)
		!power_on_reset_in |=> $stable(factors_reg) && $stable(mode_reg))
		else $error("config moved outside reset");
	a_default_factors: assert property (@(posedge aclk)
		disable iff (!aresetn)
		power_on_reset_in && straps.pci_disable_strap &&
		code_next == 7'h00 |=> factors_reg.cpm_x2 == 8'h06 &&
		factors_reg.cpu_x2 == 8'h08) else $error("default factors");
	a_host_sample: assert property (@(posedge aclk)
		disable iff (!aresetn)
		power_on_reset_in && mode_next == RCMS_PCI_HOST &&
		code_next == 7'h09 |=> factors_reg.div_x2 == 8'h06)
		else $error("host divide wrong");
	a_tick_rise: assert property (@(posedge aclk)
		disable iff (!aresetn)
		tick_reg[0] |=> ##1 tick_reg[2]) else $error("third tick off");
	a_tick_period: assert property (@(posedge aclk)
		disable iff (!aresetn)
		tick_reg[0] |=> !tick_reg[0] [*3] ##1 tick_reg[0])
		else $error("tick period not four");
	a_tick_second: assert property (@(posedge aclk)
		disable iff (!aresetn)
		tick_reg[1] |-> tick_reg[0] || $past(tick_reg[0]))
		else $error("second tick not at or after first");
	a_tick_fourth: assert property (@(posedge aclk)
		disable iff (!aresetn)
		tick_reg[3] |-> tick_reg[2] || $past(tick_reg[2]))
		else $error("fourth tick not at or after third");
	a_agent_reserved: assert property (@(posedge aclk)
		disable iff (!aresetn)
		power_on_reset_in && mode_next == RCMS_PCI_AGENT &&
		code_next == 7'h18 |=> factors_reg.reserved)
		else $error("reserved not flagged");
	a_far_decerr: assert property (@(posedge aclk)
		disable iff (!aresetn)
		s_axi_arvalid && s_axi_arready && s_axi_araddr[31:4] != 28'h0
		|=> s_axi_rresp == `RCMS_RESP_DECERR)
		else $error("far read not refused");

	c_local_capture: cover property (@(posedge aclk)
		power_on_reset_in && straps.pci_disable_strap);
	c_host_capture: cover property (@(posedge aclk)
		power_on_reset_in && mode_next == RCMS_PCI_HOST);
	c_agent_capture: cover property (@(posedge aclk)
		power_on_reset_in && mode_next == RCMS_PCI_AGENT);
	c_axi_read: cover property (@(posedge aclk) s_axi_rvalid && s_axi_rready);
	c_tick_spread: cover property (@(posedge aclk)
		tick_spread_reg && tick_reg[1]);

endmodule
`default_nettype wire

// >>> testbench/rcms_strap_source.sv
// Purpose: Board strap and configuration word source.
// Assumes: Inputs change just after a rising edge.
// Notes: The unused copy of the high bits carries their inverse, so a
// wrong pick by the selector shows up.
`timescale 1ns/1ns
`default_nettype none
module rcms_strap_source
	import rcms_pkg::*;
(
	input wire logic aclk,
	input wire logic [1:0] mode_sel,
	input wire logic range_sel,
	input wire logic [6:0] code_sel,
	input wire logic [27:0] word_low,
	output var rcms_straps_t straps
);
	logic [3:0] hi;
	logic [3:0] lines_hi;
	assign hi = code_sel[6:3];
	assign lines_hi = {hi[0], hi[1], hi[2], hi[3]};
	// ============================================================
	// Straps
	always_ff @(posedge aclk) begin
		straps.pci_disable_strap <= (mode_sel == 2'h0);
		straps.host_agent_strap <= (mode_sel == 2'h2);
		// Any code is passed through to the pins and the used copy of the high bits, reserved ones included
		straps.clock_mode_pins <= code_sel[2:0];
		if (mode_sel == 2'h0) begin
			straps.config_word <= {hi, word_low};
			straps.local_general_lines <= {~range_sel, 1'b1, ~lines_hi};
		end else begin
			straps.config_word <= {~hi, word_low};
			straps.local_general_lines <= {range_sel, 1'b0, lines_hi};
		end
	end
endmodule
`default_nettype wire

// >>> testbench/testbench.sv
// Purpose: Self-checking bench for the clock mode selector.
// Assumes: Strap source registers its inputs one edge late.
// Notes: Expected factors are in half units; -1 skips the factor check.
`timescale 1ns/1ns
`default_nettype none
`include "rcms_consts.svh"
module testbench
	import rcms_pkg::*;
();
	typedef struct {int m, r, c, comms_engine_clock, cpu, dv, rs;} rcms_row_t;
	rcms_row_t tab[8] = '{'{0, 1, 7'h00, 8'h06, 8'h08, 8'h00, 0},
		'{0, 0, 7'h08, 8'h04, 8'h08, 8'h00, 0}, '{1, 0, 7'h09, 8'h06, 8'h0C, 8'h06, 0},
		'{1, 0, 7'h29, 8'h04, 8'h06, 8'h04, 0}, '{2, 0, 7'h00, 8'h04, 8'h05, 8'h04, 0},
		'{2, 1, 7'h11, -1, 0, 0, 0}, '{1, 0, 7'h20, 8'h06, 8'h08, 8'h00, 1},
		'{2, 0, 7'h18, 8'h06, 8'h08, 8'h00, 1}};
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic por = 1'b0;
	logic [1:0] msel = 2'h0;
	logic rsel = 1'b0;
	logic [6:0] csel = 7'h00;
	logic [27:0] wlow = 28'h0;
	logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, rng_q;
	logic [1:0] bresp, rresp;
	logic [6:0] code_q;
	logic [3:0] tick_q;
	rcms_straps_t straps;
	rcms_mode_t mode_q;
	rcms_factors_t fac_q;
	int err_total = 0;
	int cmp_count = 0;
	always #10 aclk = ~aclk;
	rcms_strap_source src (.aclk(aclk), .mode_sel(msel), .range_sel(rsel),
		.code_sel(csel), .word_low(wlow), .straps(straps));
	rcms_selector uut (.aclk(aclk), .aresetn(aresetn),
		.power_on_reset_in(por), .straps(straps),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .mode_reg(mode_q), .pci_low_range_reg(rng_q),
		.config_code_reg(code_q), .factors_reg(fac_q), .tick_reg(tick_q));
	// ============================================================
	// Reporting
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic chk_port(input string nm, input logic [31:0] e, g);
		cmp_count++;
		if (g !== e) begin
			err_total++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_bus(input logic [31:0] a, e, g, input logic [1:0] er, gr);
		cmp_count++;
		if (g !== e || gr !== er) begin
			err_total++;
			$display("unexpected read %h expected %h/%h seen %h/%h", a, e, er, g, gr);
		end
	endtask
	task automatic hang();
		err_total++;
		$display("unexpected bus answer expected response seen none");
		print_verdict();
	endtask
	// ============================================================
	// Bus master; ready is looked at before the edge that takes it
	task automatic axi_wr(input logic [31:0] a, d, output logic [1:0] r);
		int n;
		logic ta, tw, tb;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(negedge aclk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bvalid;
			r = bresp;
			@(posedge aclk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (tb) break;
		end
		if (n == 50) hang();
		bready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic axi_rd(input logic [31:0] a, output logic [31:0] d,
		output logic [1:0] r);
		int n;
		logic ta, tr;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(negedge aclk);
			ta = arvalid && arready;
			tr = rvalid;
			d = rdata;
			r = rresp;
			@(posedge aclk);
			if (ta) arvalid <= 1'b0;
			if (tr) break;
		end
		if (n == 50) hang();
		rready <= 1'b0;
		@(posedge aclk);
	endtask
	// ============================================================
	// Main sequence
	initial begin
		int i, last, t2, rx;
		logic [31:0] d, sd;
		logic [1:0] r;
		sd = $urandom(34);
		last = -1;
		t2 = -1;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		for (i = 0; i < 16; i++) begin
			@(negedge aclk);
			if (i == t2) chk_port("tick2", 1, tick_q[2]);
			if (i == t2 - 1) chk_port("tick1", 1, tick_q[1]);
			if (t2 > 0 && i == t2 + 1) chk_port("tick3", 1, tick_q[3]);
			if (tick_q[0]) begin
				if (last >= 0) chk_port("tick0 gap", 4, i - last);
				last = i;
				t2 = i + 2;
			end
		end
		@(posedge aclk);
		sd = $urandom();
		axi_wr({28'h0, `RCMS_ADDR_SCRATCH}, sd, r);
		chk_bus(32'hC, {30'h0, `RCMS_RESP_OKAY}, {30'h0, r}, 2'h0, 2'h0);
		axi_rd({28'h0, `RCMS_ADDR_SCRATCH}, d, r);
		chk_bus(32'hC, {24'h0, sd[7:0]}, d, `RCMS_RESP_OKAY, r);
		axi_wr({28'h0, `RCMS_ADDR_CODE}, 32'h7F, r);
		chk_bus(32'h8, 32'h0, 32'h0, `RCMS_RESP_OKAY, r);
		axi_wr(32'h14, sd, r);
		chk_bus(32'h14, 32'h0, 32'h0, `RCMS_RESP_DECERR, r);
		axi_rd(32'h10, d, r);
		chk_bus(32'h10, 32'h0, d, `RCMS_RESP_DECERR, r);
		for (i = 0; i < 8; i++) begin
			msel <= 2'(tab[i].m);
			rsel <= 1'(tab[i].r);
			csel <= 7'(tab[i].c);
			wlow <= 28'($urandom());
			por <= 1'b1;
			repeat (3) @(posedge aclk);
			por <= 1'b0;
			msel <= 2'(2 - tab[i].m);
			csel <= ~7'(tab[i].c);
			rsel <= ~1'(tab[i].r);
			repeat (4) @(negedge aclk);
			rx = (tab[i].m != 0) ? tab[i].r : 0;
			chk_port("mode", tab[i].m, {30'h0, mode_q});
			chk_port("range", rx, {31'h0, rng_q});
			chk_port("code", tab[i].c, {25'h0, code_q});
			if (tab[i].comms_engine_clock >= 0) begin
				d = {tab[i].comms_engine_clock[7:0], tab[i].cpu[7:0], tab[i].dv[7:0]};
				chk_port("factors", {d[30:0], 1'(tab[i].rs)}, {7'h0, fac_q});
				@(posedge aclk);
				axi_rd({28'h0, `RCMS_ADDR_FACTORS}, sd, r);
				chk_bus(32'h4, d, sd, `RCMS_RESP_OKAY, r);
			end else begin
				@(posedge aclk);
			end
			axi_rd({28'h0, `RCMS_ADDR_STATUS}, sd, r);
			d = (tab[i].rs << 4) | (rx << 3) | tab[i].m;
			chk_bus(32'h0, d, sd, `RCMS_RESP_OKAY, r);
			axi_rd({28'h0, `RCMS_ADDR_CODE}, sd, r);
			chk_bus(32'h8, tab[i].c, sd, `RCMS_RESP_OKAY, r);
		end
		print_verdict();
	end
endmodule
`default_nettype wire
